// ---- shared/caller_id_pkg.sv ----
// constants shared by both ends of the caller id serial host link
// assumes a 10 MHz system clock on both ends
package caller_id_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int BAUD_RATE = 1200;
	localparam int BAUD_CYC = 1000000000 / (BAUD_RATE * CLK_PERIOD_NS);
	localparam int TENTH_MS_NS = 100000;
	localparam int TENTH_MS_CYC = TENTH_MS_NS / CLK_PERIOD_NS;
	// detector times in tenths of a millisecond
	localparam int ALERT_ACQ_SLOPE = 28;
	localparam int ALERT_ACQ_OFS = 2;
	localparam int ALERT_ACQ_BASE = 169;
	localparam int ALERT_REL_TOP = 31;
	localparam int ALERT_REL_BASE = 131;
	localparam int PROGRESS_CAPTURE_TIME = 250;
	localparam int PROGRESS_RELEASE_TIME = 300;
	localparam int DET_CNT_W = 11;
	// link frame
	localparam int FRAME_BITS = 8;
	localparam int CHAR_BITS = 8;
	localparam int UART_BITS = 10;
	localparam logic [3:0] ADDR_MODE = 4'h0;
	localparam logic [3:0] ADDR_THR_LOW = 4'h1;
	localparam logic [3:0] ADDR_THR_HIGH = 4'h2;
	localparam int MODE_SYNC_BIT = 0;
	localparam int MODE_PROGRESS_BIT = 1;
	localparam int MODE_UK_BIT = 2;
	localparam logic [3:0] REG_RESET = 4'h0;
	// host side
	localparam int SCLK_HALF_CYC = 8;
	localparam int TMR_W = 14;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h0C;
	localparam logic [7:0] OFS_RXDATA = 8'h10;
	localparam int CTRL_SYNC_BIT = 0;
	localparam int CMD_START_BIT = 8;
	localparam int CMD_BUSY_BIT = 9;
	localparam int STAT_RX_BIT = 0;
	localparam int STAT_WR_BIT = 1;
	localparam int STAT_W = 2;
endpackage

// ---- shared/caller_id_link_if.sv ----
// serial host link between the receiver and its controller
// assumes both ends run on their own clocks, link pins are plain levels
`timescale 1ns/1ps
interface caller_id_link_if;
	logic mode_pin;
	logic sclk_n;
	logic serial_in_pin;
	logic serial_out_pin;
	logic data_ready_n;
	modport device
	(
		input mode_pin,
		input sclk_n,
		input serial_in_pin,
		output serial_out_pin,
		output data_ready_n
	);
	modport host
	(
		output mode_pin,
		output sclk_n,
		output serial_in_pin,
		input serial_out_pin,
		input data_ready_n
	);
endinterface

// ---- src/caller_id_device.sv ----
// receiver end: character store, serial read-out, control register writes,
// alert and call-progress detect timers
// assumes demodulated characters arrive as one-cycle strobes on clk
`timescale 1ns/1ps
module caller_id_device #(
	parameter int TICK_CYC = caller_id_pkg::TENTH_MS_CYC,
	parameter int BAUD_CYC = caller_id_pkg::BAUD_CYC
)
(
	input wire logic clk,
	input wire logic rst,
	caller_id_link_if.device link,
	input wire logic char_valid,
	input wire logic [7:0] char_data,
	input wire logic alert_tone_raw,
	input wire logic progress_tone_raw,
	output logic alert_detect,
	output logic progress_detect,
	output logic uk_alert_mode,
	output logic [3:0] mode_control_reg,
	output logic [4:0] threshold
);
	// ==========================================================
	// pin synchronisers
	logic [2:0] sclk_s_q;
	logic [1:0] mode_s_q;
	logic [1:0] sin_s_q;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sclk_s_q <= 3'h7;
			mode_s_q <= 2'h0;
			sin_s_q <= 2'h0;
		end
		else
		begin
			sclk_s_q <= {sclk_s_q[1:0], link.sclk_n};
			mode_s_q <= {mode_s_q[0], link.mode_pin};
			sin_s_q <= {sin_s_q[0], link.serial_in_pin};
		end
	end
	logic sclk_fall;
	logic sclk_rise;
	logic mode_hi;
	assign sclk_fall = sclk_s_q[2] & ~sclk_s_q[1];
	assign sclk_rise = ~sclk_s_q[2] & sclk_s_q[1];
	assign mode_hi = mode_s_q[1];

	// ==========================================================
	// control register writes
	logic [7:0] wr_sh_q;
	logic [3:0] wr_cnt_q;
	logic [3:0] regs_q [16];
	logic [7:0] wr_frame;
	assign wr_frame = {sin_s_q[1], wr_sh_q[7:1]};
	always_ff @(posedge clk)
	begin
		if (rst || !mode_hi)
		begin
			wr_cnt_q <= 4'h0;
			wr_sh_q <= 8'h00;
		end
		else if (sclk_rise && wr_cnt_q != 4'(caller_id_pkg::FRAME_BITS))
		begin
			wr_sh_q <= wr_frame;
			wr_cnt_q <= wr_cnt_q + 4'h1;
		end
	end
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++)
		begin : g_reg
			always_ff @(posedge clk)
			begin
				if (rst)
					regs_q[gi] <= caller_id_pkg::REG_RESET;
				else if (mode_hi && sclk_rise
					&& wr_cnt_q == 4'(caller_id_pkg::FRAME_BITS - 1)
					&& wr_frame[3:0] == 4'(gi))
					regs_q[gi] <= wr_frame[7:4];
			end
		end
	endgenerate
	assign mode_control_reg = regs_q[caller_id_pkg::ADDR_MODE];
	assign threshold = {regs_q[caller_id_pkg::ADDR_THR_HIGH][0],
		regs_q[caller_id_pkg::ADDR_THR_LOW]};
	assign uk_alert_mode = mode_control_reg[caller_id_pkg::MODE_UK_BIT];

	// ==========================================================
	// character store and read-out
	logic ready_q;
	logic [7:0] rd_sh_q;
	logic [3:0] rd_cnt_q;
	logic tx_active_q;
	logic [9:0] tx_frame_q;
	logic [3:0] tx_idx_q;
	logic [13:0] baud_q;
	logic out_q;
	logic sync_mode;
	logic shifting;
	assign sync_mode = mode_control_reg[caller_id_pkg::MODE_SYNC_BIT];
	assign shifting = tx_active_q | (rd_cnt_q != 4'h0);
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ready_q <= 1'b0;
			rd_sh_q <= 8'h00;
			rd_cnt_q <= 4'h0;
			tx_active_q <= 1'b0;
			tx_frame_q <= 10'h3FF;
			tx_idx_q <= 4'h0;
			baud_q <= 14'h0000;
			out_q <= 1'b1;
		end
		else if (char_valid && !shifting)
		begin
			rd_sh_q <= char_data;
			ready_q <= 1'b1;
		end
		else if (tx_active_q)
		begin
			out_q <= tx_frame_q[tx_idx_q];
			if (baud_q == 14'(BAUD_CYC - 1))
			begin
				baud_q <= 14'h0000;
				if (tx_idx_q == 4'(caller_id_pkg::UART_BITS - 1))
				begin
					tx_active_q <= 1'b0;
					ready_q <= 1'b0;
					tx_idx_q <= 4'h0;
				end
				else
					tx_idx_q <= tx_idx_q + 4'h1;
			end
			else
				baud_q <= baud_q + 14'h0001;
		end
		else if (ready_q && !mode_hi && !sync_mode)
		begin
			tx_active_q <= 1'b1;
			tx_frame_q <= {1'b1, rd_sh_q, 1'b0};
			tx_idx_q <= 4'h0;
			baud_q <= 14'h0000;
		end
		else if (ready_q && !mode_hi && sync_mode)
		begin
			if (sclk_fall)
				out_q <= rd_sh_q[rd_cnt_q[2:0]];
			else if (sclk_rise)
			begin
				if (rd_cnt_q == 4'(caller_id_pkg::CHAR_BITS - 1))
				begin
					rd_cnt_q <= 4'h0;
					ready_q <= 1'b0;
				end
				else
					rd_cnt_q <= rd_cnt_q + 4'h1;
			end
		end
		else
			out_q <= 1'b1;
	end

	// ==========================================================
	// detect timers: channel 0 alert tone, channel 1 call progress
	logic [13:0] tick_q;
	logic tick;
	always_ff @(posedge clk)
	begin
		if (rst || tick)
			tick_q <= 14'h0000;
		else
			tick_q <= tick_q + 14'h0001;
	end
	assign tick = tick_q == 14'(TICK_CYC - 1);

	localparam int W = caller_id_pkg::DET_CNT_W;
	logic [W-1:0] acq_t [2];
	logic [W-1:0] rel_t [2];
	logic raw [2];
	logic det_q [2];
	logic [W-1:0] cnt_q [2];
	logic progress_mode;
	assign progress_mode = mode_control_reg[caller_id_pkg::MODE_PROGRESS_BIT];
	assign acq_t[0] = W'(caller_id_pkg::ALERT_ACQ_SLOPE)
		* (W'(threshold) + W'(caller_id_pkg::ALERT_ACQ_OFS))
		+ W'(caller_id_pkg::ALERT_ACQ_BASE);
	assign rel_t[0] = W'(caller_id_pkg::ALERT_ACQ_SLOPE)
		* (W'(caller_id_pkg::ALERT_REL_TOP) - W'(threshold))
		+ W'(caller_id_pkg::ALERT_REL_BASE);
	assign acq_t[1] = W'(caller_id_pkg::PROGRESS_CAPTURE_TIME);
	assign rel_t[1] = W'(caller_id_pkg::PROGRESS_RELEASE_TIME);
	assign raw[0] = alert_tone_raw & ~progress_mode;
	assign raw[1] = progress_tone_raw & progress_mode;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_det
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					det_q[gi] <= 1'b0;
					cnt_q[gi] <= '0;
				end
				else if (raw[gi] == det_q[gi])
					cnt_q[gi] <= '0;
				else if (tick)
				begin
					if (cnt_q[gi] + W'(1) >= (det_q[gi] ? rel_t[gi] : acq_t[gi]))
					begin
						det_q[gi] <= raw[gi];
						cnt_q[gi] <= '0;
					end
					else
						cnt_q[gi] <= cnt_q[gi] + W'(1);
				end
			end
		end
	endgenerate
	assign alert_detect = det_q[0];
	assign progress_detect = det_q[1];

	// ==========================================================
	// link outputs
	logic ready_n_q;
	always_ff @(posedge clk)
	begin
		if (rst)
			ready_n_q <= 1'b1;
		else
			ready_n_q <= ~(ready_q | det_q[1]);
	end
	assign link.data_ready_n = ready_n_q;
	assign link.serial_out_pin = out_q;
endmodule

// ---- src/caller_id_host.sv ----
// controller end: apb register slave that writes receiver control
// registers and reads received characters in sync or async form
// assumes an apb master on clk and a receiver on the link pins
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module caller_id_host #(
	parameter int BAUD_CYC = caller_id_pkg::BAUD_CYC
)
(
	input wire logic clk,
	input wire logic rst,
	caller_id_link_if.host link,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq
);
	typedef enum {ST_IDLE, ST_WR_RST, ST_WR_GAP, ST_WR_LO, ST_WR_HI, ST_RD_LO,
		ST_RD_HI, ST_RX_START, ST_RX_BITS, ST_RX_STOP, ST_WAIT} state_e;
	localparam int HALF = caller_id_pkg::SCLK_HALF_CYC;
	localparam int TW = caller_id_pkg::TMR_W;

	// ==========================================================
	// apb registers
	logic sync_q;
	logic wr_req_q;
	logic [7:0] wr_frame_q;
	logic [1:0] status_q;
	logic [1:0] mask_q;
	logic [7:0] rx_data_q;
	logic rx_done;
	logic wr_done;
	logic take_wr;
	state_e state_q;
	logic setup;
	logic wr_acc;
	logic unmapped;
	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;
	assign unmapped = !(paddr inside {caller_id_pkg::OFS_CTRL, caller_id_pkg::OFS_CMD,
		caller_id_pkg::OFS_STATUS, caller_id_pkg::OFS_MASK, caller_id_pkg::OFS_RXDATA});
	assign pready = 1'b1;
	assign pslverr = psel & penable & unmapped;
	always_ff @(posedge clk)
	begin
		if (rst)
			prdata <= 32'h00000000;
		else if (setup)
			case (paddr)
				caller_id_pkg::OFS_CTRL: prdata <= {31'h0, sync_q};
				caller_id_pkg::OFS_CMD: prdata <= {22'h0, wr_req_q | (state_q != ST_IDLE),
					wr_req_q, wr_frame_q};
				caller_id_pkg::OFS_STATUS: prdata <= {30'h0, status_q};
				caller_id_pkg::OFS_MASK: prdata <= {30'h0, mask_q};
				caller_id_pkg::OFS_RXDATA: prdata <= {24'h0, rx_data_q};
				default: prdata <= 32'h00000000;
			endcase
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sync_q <= 1'b0;
			mask_q <= 2'h0;
		end
		else if (wr_acc && paddr == caller_id_pkg::OFS_CTRL)
			sync_q <= pwdata[caller_id_pkg::CTRL_SYNC_BIT];
		else if (wr_acc && paddr == caller_id_pkg::OFS_MASK)
			mask_q <= pwdata[1:0];
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_req_q <= 1'b0;
			wr_frame_q <= 8'h00;
		end
		else if (wr_acc && paddr == caller_id_pkg::OFS_CMD && !wr_req_q
			&& pwdata[caller_id_pkg::CMD_START_BIT])
		begin
			wr_req_q <= 1'b1;
			wr_frame_q <= pwdata[7:0];
		end
		else if (take_wr)
			wr_req_q <= 1'b0;
	end
	// set wins over write-one-to-clear
	always_ff @(posedge clk)
	begin
		if (rst)
			status_q <= 2'h0;
		else
			status_q <= (status_q & ~((wr_acc && paddr == caller_id_pkg::OFS_STATUS)
				? pwdata[1:0] : 2'h0)) | {wr_done, rx_done};
	end
	assign irq = |(status_q & mask_q);

	// ==========================================================
	// link side
	logic [1:0] so_s_q;
	logic so_old_q;
	logic [1:0] rdy_s_q;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			so_s_q <= 2'h3;
			so_old_q <= 1'b1;
			rdy_s_q <= 2'h3;
		end
		else
		begin
			so_s_q <= {so_s_q[0], link.serial_out_pin};
			so_old_q <= so_s_q[1];
			rdy_s_q <= {rdy_s_q[0], link.data_ready_n};
		end
	end
	logic [TW-1:0] tmr_q;
	logic [3:0] idx_q;
	logic [7:0] rx_sh_q;
	logic mode_q;
	logic sclk_q;
	logic sin_q;
	logic expired;
	assign expired = tmr_q == '0;
	assign take_wr = state_q == ST_IDLE && wr_req_q;
	assign rx_done = (state_q == ST_RD_HI && expired && idx_q == 4'h7)
		|| (state_q == ST_RX_STOP && expired);
	assign wr_done = state_q == ST_WR_HI && expired && idx_q == 4'h7;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_q <= ST_IDLE;
			tmr_q <= '0;
			idx_q <= 4'h0;
			rx_sh_q <= 8'h00;
			rx_data_q <= 8'h00;
			mode_q <= 1'b0;
			sclk_q <= 1'b1;
			sin_q <= 1'b0;
		end
		else if (!expired)
			tmr_q <= tmr_q - TW'(1);
		else
			case (state_q)
				ST_IDLE:
				begin
					idx_q <= 4'h0;
					if (wr_req_q)
					begin
						mode_q <= 1'b0;
						tmr_q <= TW'(HALF - 1);
						state_q <= ST_WR_RST;
					end
					else if (sync_q && !rdy_s_q[1])
					begin
						sclk_q <= 1'b0;
						tmr_q <= TW'(HALF - 1);
						state_q <= ST_RD_LO;
					end
					else if (!sync_q && so_old_q && !so_s_q[1])
					begin
						tmr_q <= TW'(BAUD_CYC / 2 - 1);
						state_q <= ST_RX_START;
					end
				end
				ST_WR_RST:
				begin
					mode_q <= 1'b1;
					tmr_q <= TW'(HALF - 1);
					state_q <= ST_WR_GAP;
				end
				ST_WR_GAP, ST_WR_HI:
				begin
					if (state_q == ST_WR_HI && idx_q == 4'h7)
					begin
						mode_q <= 1'b0;
						tmr_q <= TW'(2 * HALF - 1);
						state_q <= ST_WAIT;
					end
					else
					begin
						if (state_q == ST_WR_HI)
							idx_q <= idx_q + 4'h1;
						sin_q <= wr_frame_q[state_q == ST_WR_HI ? idx_q[2:0] + 3'h1 : 3'h0];
						sclk_q <= 1'b0;
						tmr_q <= TW'(HALF - 1);
						state_q <= ST_WR_LO;
					end
				end
				ST_WR_LO:
				begin
					sclk_q <= 1'b1;
					tmr_q <= TW'(HALF - 1);
					state_q <= ST_WR_HI;
				end
				ST_RD_LO:
				begin
					sclk_q <= 1'b1;
					rx_sh_q <= {so_s_q[1], rx_sh_q[7:1]};
					tmr_q <= TW'(HALF - 1);
					state_q <= ST_RD_HI;
				end
				ST_RD_HI:
				begin
					if (idx_q == 4'h7)
					begin
						rx_data_q <= rx_sh_q;
						tmr_q <= TW'(2 * HALF - 1);
						state_q <= ST_WAIT;
					end
					else
					begin
						idx_q <= idx_q + 4'h1;
						sclk_q <= 1'b0;
						tmr_q <= TW'(HALF - 1);
						state_q <= ST_RD_LO;
					end
				end
				ST_RX_START:
				begin
					tmr_q <= TW'(BAUD_CYC - 1);
					state_q <= so_s_q[1] ? ST_IDLE : ST_RX_BITS;
				end
				ST_RX_BITS:
				begin
					rx_sh_q <= {so_s_q[1], rx_sh_q[7:1]};
					tmr_q <= TW'(BAUD_CYC - 1);
					idx_q <= idx_q + 4'h1;
					if (idx_q == 4'h7)
						state_q <= ST_RX_STOP;
				end
				ST_RX_STOP:
				begin
					rx_data_q <= rx_sh_q;
					state_q <= ST_IDLE;
				end
				ST_WAIT:
					state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
	end
	assign link.mode_pin = mode_q;
	assign link.sclk_n = sclk_q;
	assign link.serial_in_pin = sin_q;
endmodule

// ---- tb/caller_id_assertions.sv ----
// checker for the serial link joining the receiver and its controller
// assumes the link signals as plain inputs and the system clk and rst
`timescale 1ns/1ps
module caller_id_assertions #(
	parameter int BAUD_CYC = caller_id_pkg::BAUD_CYC
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic mode_pin,
	input wire logic sclk_n,
	input wire logic serial_in_pin,
	input wire logic serial_out_pin,
	input wire logic data_ready_n
);
	localparam int ASY_LO = 9 * BAUD_CYC;
	localparam int ASY_HI = 10 * BAUD_CYC + 4;
	logic sclk_q, rise, sync_rd, async_rd;
	logic [3:0] wr_cnt_q, rd_cnt_q, reg0_q;
	logic [7:0] frame_q;
	// ==========================================
	// link decode, tracks the mode register
	assign rise = sclk_n && !sclk_q;
	assign sync_rd = !mode_pin && reg0_q[0] && !reg0_q[1];
	assign async_rd = !mode_pin && !reg0_q[0] && !reg0_q[1];
	always_ff @(posedge clk)
		sclk_q <= rst ? 1'b1 : sclk_n;
	always_ff @(posedge clk)
		if (rst || !mode_pin)
			wr_cnt_q <= 4'h0;
		else if (rise)
			wr_cnt_q <= wr_cnt_q + 4'h1;
	always_ff @(posedge clk)
		if (rise && mode_pin)
			frame_q <= {serial_in_pin, frame_q[7:1]};
	always_ff @(posedge clk)
		if (rst)
			reg0_q <= 4'h0;
		else if (!mode_pin && wr_cnt_q == 4'h8 && frame_q[3:0] == 4'h0)
			reg0_q <= frame_q[7:4];
	always_ff @(posedge clk)
		if (rst || mode_pin || data_ready_n)
			rd_cnt_q <= 4'h0;
		else if (rise)
			rd_cnt_q <= rd_cnt_q + 4'h1;
	// ==========================================
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_low_phase;
		(!sclk_n) [*8] ##1 sclk_n;
	endsequence
	sequence s_async_start;
		##[0:3] $fell(serial_out_pin) ##1 (!serial_out_pin) [*8];
	endsequence
	property p_mode_setup;
		$rose(mode_pin) |-> (mode_pin && sclk_n) [*8];
	endproperty
	property p_mode_hold;
		mode_pin && $fell(sclk_n) |-> mode_pin [*8] ##1 mode_pin;
	endproperty
	property p_sclk_low;
		$fell(sclk_n) |-> s_low_phase;
	endproperty
	property p_sin_stable;
		mode_pin && sclk_n && $past(sclk_n) |-> $stable(serial_in_pin);
	endproperty
	property p_frame_len;
		$fell(mode_pin) |-> wr_cnt_q == 4'h8;
	endproperty
	property p_sync_hold;
		sync_rd && !data_ready_n && rd_cnt_q < 4'h7 |=> !data_ready_n;
	endproperty
	property p_sync_release;
		sync_rd && rise && rd_cnt_q == 4'h7 |-> ##[1:8] data_ready_n;
	endproperty
	property p_sdo_on_fall;
		sync_rd && !data_ready_n && $changed(serial_out_pin) |-> !sclk_n;
	endproperty
	property p_async_start;
		async_rd && $fell(data_ready_n) |-> s_async_start;
	endproperty
	property p_async_len;
		async_rd && $fell(data_ready_n) |-> ##[ASY_LO:ASY_HI] data_ready_n;
	endproperty
	a_mode_setup: assert property (p_mode_setup) else $error("mode rise too close");
	a_mode_hold: assert property (p_mode_hold) else $error("mode dropped in frame");
	a_sclk_low: assert property (p_sclk_low) else $error("clock low phase length");
	a_sin_stable: assert property (p_sin_stable) else $error("input moved at clock high");
	a_frame_len: assert property (p_frame_len) else $error("frame not eight bits");
	a_sync_hold: assert property (p_sync_hold) else $error("ready released early");
	a_sync_release: assert property (p_sync_release) else $error("ready not released");
	a_sdo_on_fall: assert property (p_sdo_on_fall) else $error("output moved off fall");
	a_async_start: assert property (p_async_start) else $error("start bit missing");
	a_async_len: assert property (p_async_len) else $error("character length");
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench: both link ends joined, apb master tasks on the controller
// assumes 10 MHz clock, short tick and baud parameters keep the run brief
`timescale 1ns/1ps
module tb_top;
	localparam int TICK = 2;
	localparam int BAUD = 20;
	localparam int SLACK = 6;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, er;
	logic [7:0] paddr, char_data;
	logic [31:0] pwdata, prdata, rd;
	logic char_valid, alert_tone_raw, progress_tone_raw, alert_detect, progress_detect;
	logic uk_alert_mode;
	logic [3:0] mode_control_reg, r0, r1, r2;
	logic [4:0] threshold;
	logic [1:0] mask_v;
	int err_count, cmp_count, t_on, t_off;
	logic [7:0] chars [4] = '{8'h1E, 8'hC1, 8'h2D, 8'h80};
	caller_id_link_if link();
	caller_id_device #(.TICK_CYC(TICK), .BAUD_CYC(BAUD)) u_caller_id_device
	(
		.clk(clk), .rst(rst), .link(link), .char_valid(char_valid), .char_data(char_data),
		.alert_tone_raw(alert_tone_raw), .progress_tone_raw(progress_tone_raw),
		.alert_detect(alert_detect), .progress_detect(progress_detect),
		.uk_alert_mode(uk_alert_mode), .mode_control_reg(mode_control_reg),
		.threshold(threshold)
	);
	caller_id_host #(.BAUD_CYC(BAUD)) u_caller_id_host
	(
		.clk(clk), .rst(rst), .link(link), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq)
	);
	caller_id_assertions #(.BAUD_CYC(BAUD)) u_caller_id_assertions
	(
		.clk(clk), .rst(rst), .mode_pin(link.mode_pin), .sclk_n(link.sclk_n),
		.serial_in_pin(link.serial_in_pin), .serial_out_pin(link.serial_out_pin),
		.data_ready_n(link.data_ready_n)
	);
	// ==========================================
	// report and compare
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic hang();
		err_count++;
		$display("BAD t=%0t wait ran out", $time);
		wrap_up();
	endtask
	// ==========================================
	// apb transfer, read data and error land in rd and er
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 100);
		if (n >= 100)
			hang();
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_stat(input int b);
		int n;
		n = 0;
		do
		begin
			apb(1'b0, caller_id_pkg::OFS_STATUS, 32'h0);
			n++;
		end
		while (rd[b] !== 1'b1 && n < 400);
		if (n >= 400)
			hang();
	endtask
	// ==========================================
	// receiver register write over the link
	task automatic dev_write(input logic [3:0] a, input logic [3:0] d);
		logic [8:0] prev_regs;
		prev_regs = {threshold, mode_control_reg};
		apb(1'b1, caller_id_pkg::OFS_CMD, {23'h0, 1'b1, d, a});
		repeat (100) @(posedge clk);
		check({23'h0, threshold, mode_control_reg}, {23'h0, prev_regs}, "early load");
		wait_stat(caller_id_pkg::STAT_WR_BIT);
		check({31'h0, irq}, {31'h0, mask_v[1]}, "irq write");
		apb(1'b0, caller_id_pkg::OFS_CMD, 32'h0);
		check({24'h0, rd[7:0]}, {24'h0, d, a}, "frame");
		apb(1'b1, caller_id_pkg::OFS_STATUS, 32'h2);
		repeat (8) @(posedge clk);
		if (a == 4'h0)
			r0 = d;
		if (a == 4'h1)
			r1 = d;
		if (a == 4'h2)
			r2 = d;
		check({23'h0, threshold, mode_control_reg}, {23'h0, r2[0], r1, r0}, "regs");
		check({31'h0, uk_alert_mode}, {31'h0, r0[2]}, "uk mode");
	endtask
	// ==========================================
	// one received character through to the controller
	task automatic rx_char(input logic [7:0] c);
		@(posedge clk);
		char_valid <= 1'b1;
		char_data <= c;
		@(posedge clk);
		char_valid <= 1'b0;
		repeat (3) @(posedge clk);
		check({31'h0, link.data_ready_n}, 32'h0, "ready low");
		wait_stat(caller_id_pkg::STAT_RX_BIT);
		check({31'h0, irq}, {31'h0, mask_v[0]}, "irq rx");
		apb(1'b0, caller_id_pkg::OFS_RXDATA, 32'h0);
		check(rd, {24'h0, c}, "char");
		repeat (BAUD) @(posedge clk);
		check({31'h0, link.data_ready_n}, 32'h1, "ready released");
		apb(1'b1, caller_id_pkg::OFS_STATUS, 32'h1);
		apb(1'b0, caller_id_pkg::OFS_STATUS, 32'h0);
		check(rd, 32'h0, "status clear");
		check({31'h0, irq}, 32'h0, "irq clear");
	endtask
	task automatic tone(input logic prog, input logic lvl, input int t);
		@(posedge clk);
		if (prog)
			progress_tone_raw <= lvl;
		else
			alert_tone_raw <= lvl;
		repeat (t - SLACK) @(posedge clk);
		check({31'h0, prog ? progress_detect : alert_detect}, {31'h0, !lvl}, "detect early");
		repeat (2 * SLACK) @(posedge clk);
		check({31'h0, prog ? progress_detect : alert_detect}, {31'h0, lvl}, "detect late");
		if (prog)
			check({31'h0, link.data_ready_n}, {31'h0, !lvl}, "ready by tone");
	endtask
	// ==========================================
	// main sequence
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		{rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
		{char_valid, char_data, alert_tone_raw, progress_tone_raw} = 11'h0;
		{r0, r1, r2, mask_v, err_count, cmp_count} = {14'h0, 64'h0};
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		check({30'h0, link.serial_out_pin, link.data_ready_n}, 32'h3, "idle pins");
		apb(1'b0, caller_id_pkg::OFS_STATUS, 32'h0);
		check(rd, 32'h0, "status reset");
		apb(1'b0, 8'hF0, 32'h0);
		check({rd[30:0], er}, 32'h1, "unmapped read");
		dev_write(4'h1, 4'hA);
		dev_write(4'h2, 4'h1);
		dev_write(4'h0, 4'h4);
		mask_v = 2'h3;
		apb(1'b1, caller_id_pkg::OFS_MASK, {30'h0, mask_v});
		for (int m = 0; m < 2; m++)
		begin
			dev_write(4'h0, m[3:0]);
			apb(1'b1, caller_id_pkg::OFS_CTRL, m);
			rx_char(chars[2 * m]);
			rx_char(chars[2 * m + 1]);
		end
		t_on = caller_id_pkg::ALERT_ACQ_SLOPE * (26 + caller_id_pkg::ALERT_ACQ_OFS);
		t_on = (t_on + caller_id_pkg::ALERT_ACQ_BASE) * TICK;
		t_off = caller_id_pkg::ALERT_ACQ_SLOPE * (caller_id_pkg::ALERT_REL_TOP - 26);
		t_off = (t_off + caller_id_pkg::ALERT_REL_BASE) * TICK;
		tone(1'b0, 1'b1, t_on);
		tone(1'b0, 1'b0, t_off);
		dev_write(4'h0, 4'h2);
		// controller read form must follow receiver mode bit 0
		apb(1'b1, caller_id_pkg::OFS_CTRL, 32'h0);
		tone(1'b1, 1'b1, caller_id_pkg::PROGRESS_CAPTURE_TIME * TICK);
		tone(1'b1, 1'b0, caller_id_pkg::PROGRESS_RELEASE_TIME * TICK);
		wrap_up();
	end
endmodule
